// ===== lpw_pkg.sv
// shared constants for the low-power wake and warm-up controller
// assumes one 25 MHz clock, synchronous active-high reset, APB register access
package lpw_pkg;
    // wake source vector layout
    localparam int WAKE_W = 14;
    localparam int EXT_LSB = 0; // ext_pin_irqs occupy [7:0]
    localparam int RTC_BIT = 8; // rtc_irq
    localparam int CEC_LSB = 9; // cec_irqs [10:9]
    localparam int RMC_LSB = 11; // remote_rx_irqs [12:11]
    localparam int OTHER_BIT = 13; // timer/capture/serial/serial_bus/adc irqs, ORed
    localparam logic [13:0] PERMIT_IDLE = 14'h3fff;
    localparam logic [13:0] PERMIT_SLEEP = 14'h1fff;
    localparam logic [13:0] PERMIT_STOP = 14'h00ff;

    // standby mode codes
    localparam logic [2:0] MODE_STOP = 3'h1;
    localparam logic [2:0] MODE_SLEEP = 3'h2;
    localparam logic [2:0] MODE_IDLE = 3'h3;

    // register offsets
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_STANDBY = 8'h00;
    localparam logic [7:0] OFS_OSC = 8'h04;
    localparam logic [7:0] OFS_WAKE_EN = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;

    // field positions
    localparam int STBY_MODE_LSB = 0;
    localparam int STBY_RUNLOW_BIT = 4;
    localparam int OSC_WSEL_BIT = 0;
    localparam int OSC_WTIME_LSB = 1;
    localparam int OSC_HSEN_BIT = 4;
    localparam int OSC_LSEN_BIT = 5;
    localparam int OSC_WSTART_BIT = 6;
    localparam int ST_STATE_LSB = 0;
    localparam int ST_RUNLOW_BIT = 5;
    localparam int ST_WBUSY_BIT = 6;
    localparam int ST_KIND_LSB = 8;

    // reset values
    localparam logic [4:0] STANDBY_RST = 5'h00;
    localparam logic [5:0] OSC_RST = 6'h30;
    localparam logic [13:0] WAKE_EN_RST = 14'h0000;

    // timing
    localparam int CLK_MHZ = 25;
    localparam int PLL_SETTLE_US = 200;
    localparam int PLL_SETTLE_CYC = PLL_SETTLE_US * CLK_MHZ;
    localparam int WU_BASE_SHIFT = 8;
    localparam int WU_CNT_W = 16;

    // wake cause codes
    localparam logic [1:0] KIND_NONE = 2'h0;
    localparam logic [1:0] KIND_IRQ = 2'h1;
    localparam logic [1:0] KIND_NMI_PIN = 2'h2;
    localparam logic [1:0] KIND_WDT = 2'h3;

    typedef enum logic [4:0] {
        ST_RUN = 5'b00001,
        ST_IDLE = 5'b00010,
        ST_SLEEP = 5'b00100,
        ST_STOP = 5'b01000,
        ST_WARM = 5'b10000
    } pwr_state_t;
endpackage : lpw_pkg

// ===== lpw_link_if.sv
// link between the standby controller and the cpu core side
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface lpw_link_if;
    logic wait_for_irq_instr;
    logic [13:0] irq_lines;
    logic nmi_pin_n;
    logic wdt_nmi;
    logic core_halt;
    logic sys_clk_en;
    logic wake_go;
    logic [1:0] wake_kind;

    modport dev (
        input wait_for_irq_instr, irq_lines, nmi_pin_n, wdt_nmi,
        output core_halt, sys_clk_en, wake_go, wake_kind
    );
    modport host (
        output wait_for_irq_instr, irq_lines, nmi_pin_n, wdt_nmi,
        input core_halt, sys_clk_en, wake_go, wake_kind
    );
endinterface : lpw_link_if

// ===== lpw_warmup_counter.sv
// oscillator warm-up counter: counts ticks of the chosen oscillator
// assumes tick inputs are one-cycle pulses already in the i_clk domain
`timescale 1ns/1ns
module lpw_warmup_counter #(
    parameter int BASE_SHIFT = lpw_pkg::WU_BASE_SHIFT
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // control
    input wire logic i_start,
    input wire logic i_sel,
    input wire logic [2:0] i_time_sel,
    // oscillator ticks
    input wire logic i_hs_tick,
    input wire logic i_ls_tick,
    // result
    output logic o_busy,
    output logic o_done
);
    import lpw_pkg::*;

    logic [WU_CNT_W-1:0] cnt_reg, cnt_next;
    logic [WU_CNT_W-1:0] limit_reg, limit_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic tick;

    // count selected oscillator up to limit, then flag done
    always_comb begin
        tick = i_sel ? i_ls_tick : i_hs_tick;
        cnt_next = cnt_reg;
        limit_next = limit_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        if (i_start) begin
            cnt_next = '0;
            limit_next = WU_CNT_W'((1 << (BASE_SHIFT + int'(i_time_sel))) - 1);
            busy_next = 1'b1;
        end else if (busy_reg && tick) begin
            if (cnt_reg == limit_reg) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
    end

    // state registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_reg <= '0;
            limit_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            limit_reg <= limit_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign o_busy = busy_reg;
    assign o_done = done_reg;
endmodule : lpw_warmup_counter

// ===== lpw_standby_ctrl.sv
// standby entry, wake filtering, warm-up and run-mode return
// assumes APB master on i_clk; oscillator tick inputs are asynchronous
`timescale 1ns/1ns
// Overview of operation
// - leave standby only on permitted wake source
// - per-mode permit masks for wake interrupts
// - watchdog nmi wakes from idle only
// - nmi pin falling edge wakes every mode
// - signal handling start after standby exit
// - software sets wake enables for sleep/stop
// - level wake request held until handling
// - software masks non-wake interrupts first
// - reset returns high-speed run, clears registers but osc enable bits
// - reset exit skips warm-up; hold reset
// - auto warm-up then enable system clock
// - software sets warm-up oscillator and time
// - pll off in sleep/stop, settle time
// - high to low run: enable, manual warm-up
// - low to high run: enable, warm-up
// - low run stop round trip warms up
// - low osc runs in sleep, no warm-up
// - mode field plus wfi enters standby
// - wake returns to prior run mode
module lpw_standby_ctrl #(
    parameter int PLL_CYC = lpw_pkg::PLL_SETTLE_CYC,
    parameter int WU_SHIFT = lpw_pkg::WU_BASE_SHIFT
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [lpw_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // oscillators
    input wire logic i_hs_osc_clk,
    input wire logic i_ls_osc_clk,
    output logic o_hs_osc_en,
    output logic o_ls_osc_en,
    output logic o_pll_en,
    // cpu link
    lpw_link_if.dev link
);
    import lpw_pkg::*;

    localparam logic [12:0] PLL_LOAD = 13'(PLL_CYC);

    pwr_state_t state_reg, state_next;
    logic [4:0] standby_reg, standby_next;
    logic [5:0] osc_reg, osc_next;
    logic [13:0] wake_en_reg, wake_en_next;
    logic run_low_reg, run_low_next;
    logic manual_reg, manual_next;
    logic wu_ok_reg, wu_ok_next;
    logic [12:0] pll_cnt_reg, pll_cnt_next;
    logic nmi_prev_reg, nmi_prev_next;
    logic [1:0] kind_reg, kind_next;
    logic halt_reg, halt_next;
    logic clk_en_reg, clk_en_next;
    logic go_reg, go_next;
    logic hs_en_reg, hs_en_next;
    logic ls_en_reg, ls_en_next;
    logic pll_en_reg, pll_en_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic [2:0] hs_sync_reg, ls_sync_reg;
    logic wr_en, sw_start, wu_start, wu_busy, wu_done;
    logic [13:0] permit;
    logic nmi_fall, wake_any, need_warm;
    logic [1:0] wake_kind;

    // oscillator synchronisers; edge taken from stages two and three
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            hs_sync_reg <= 3'h0;
            ls_sync_reg <= 3'h0;
        end else begin
            hs_sync_reg <= {hs_sync_reg[1:0], i_hs_osc_clk};
            ls_sync_reg <= {ls_sync_reg[1:0], i_ls_osc_clk};
        end
    end

    lpw_warmup_counter #(.BASE_SHIFT(WU_SHIFT)) u_warm (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_start(wu_start),
        .i_sel(osc_reg[OSC_WSEL_BIT]),
        .i_time_sel(osc_reg[OSC_WTIME_LSB +: 3]),
        .i_hs_tick(hs_sync_reg[1] & ~hs_sync_reg[2]),
        .i_ls_tick(ls_sync_reg[1] & ~ls_sync_reg[2]),
        .o_busy(wu_busy),
        .o_done(wu_done)
    );

    // apb decode, register writes and read mux
    always_comb begin
        wr_en = i_psel & i_penable & i_pwrite & pready_reg;
        pready_next = i_psel & ~i_penable;
        pslverr_next = 1'b0;
        prdata_next = prdata_reg;
        standby_next = standby_reg;
        osc_next = osc_reg;
        wake_en_next = wake_en_reg;
        sw_start = 1'b0;
        if (i_psel && !i_penable) begin
            prdata_next = 32'h0;
            unique case (i_paddr)
                OFS_STANDBY: prdata_next[4:0] = standby_reg;
                OFS_OSC: prdata_next[5:0] = osc_reg;
                OFS_WAKE_EN: prdata_next[13:0] = wake_en_reg;
                OFS_STATUS: begin
                    prdata_next[ST_STATE_LSB +: 5] = state_reg;
                    prdata_next[ST_RUNLOW_BIT] = run_low_reg;
                    prdata_next[ST_WBUSY_BIT] = wu_busy | (state_reg == ST_WARM);
                    prdata_next[ST_KIND_LSB +: 2] = kind_reg;
                end
                default: pslverr_next = 1'b1;
            endcase
        end
        if (wr_en) begin
            unique case (i_paddr)
                OFS_STANDBY: standby_next = i_pwdata[4:0];
                OFS_OSC: begin
                    osc_next = i_pwdata[5:0];
                    sw_start = i_pwdata[OSC_WSTART_BIT];
                end
                OFS_WAKE_EN: wake_en_next = i_pwdata[13:0];
                default: ;
            endcase
        end
    end

    // power state machine, wake filtering and warm-up sequencing
    always_comb begin
        state_next = state_reg;
        run_low_next = run_low_reg;
        manual_next = manual_reg;
        wu_ok_next = wu_ok_reg | wu_done;
        pll_cnt_next = (pll_cnt_reg != 13'h0) ? pll_cnt_reg - 13'h1 : 13'h0;
        kind_next = kind_reg;
        go_next = 1'b0;
        wu_start = 1'b0;
        nmi_prev_next = link.nmi_pin_n;
        nmi_fall = nmi_prev_reg & ~link.nmi_pin_n;
        unique case (state_reg)
            ST_IDLE: permit = PERMIT_IDLE;
            ST_SLEEP: permit = PERMIT_SLEEP & wake_en_reg;
            ST_STOP: permit = PERMIT_STOP & wake_en_reg;
            default: permit = 14'h0;
        endcase
        wake_any = (|(link.irq_lines & permit)) | nmi_fall
            | (link.wdt_nmi & (state_reg == ST_IDLE));
        if (nmi_fall) wake_kind = KIND_NMI_PIN;
        else if (link.wdt_nmi && state_reg == ST_IDLE) wake_kind = KIND_WDT;
        else wake_kind = KIND_IRQ;
        need_warm = (state_reg == ST_STOP)
            || (state_reg == ST_SLEEP && !run_low_reg);
        unique case (state_reg)
            ST_RUN: begin
                if (sw_start && !wu_busy) begin
                    wu_start = 1'b1;
                    manual_next = 1'b1;
                end else if (link.wait_for_irq_instr && !wu_busy && !manual_reg) begin
                    unique case (standby_reg[STBY_MODE_LSB +: 3])
                        MODE_STOP: state_next = ST_STOP;
                        MODE_SLEEP: state_next = ST_SLEEP;
                        MODE_IDLE: state_next = ST_IDLE;
                        default: state_next = ST_RUN;
                    endcase
                end
                if (manual_reg && wu_done) begin
                    manual_next = 1'b0;
                    run_low_next = standby_reg[STBY_RUNLOW_BIT];
                end
            end
            ST_IDLE, ST_SLEEP, ST_STOP: begin
                if (wake_any) begin
                    kind_next = wake_kind;
                    if (need_warm) begin
                        state_next = ST_WARM;
                        wu_start = 1'b1;
                        wu_ok_next = 1'b0;
                        pll_cnt_next = run_low_reg ? 13'h0 : PLL_LOAD;
                    end else begin
                        state_next = ST_RUN;
                        go_next = 1'b1;
                    end
                end
            end
            ST_WARM: begin
                if (wu_ok_reg && pll_cnt_reg == 13'h0) begin
                    state_next = ST_RUN;
                    go_next = 1'b1;
                end
            end
            default: state_next = ST_RUN;
        endcase
        halt_next = (state_next != ST_RUN);
        clk_en_next = (state_next == ST_RUN) || (state_next == ST_IDLE);
        hs_en_next = osc_reg[OSC_HSEN_BIT]
            && state_next != ST_SLEEP && state_next != ST_STOP;
        ls_en_next = osc_reg[OSC_LSEN_BIT] && state_next != ST_STOP;
        pll_en_next = hs_en_next && !run_low_next;
    end

    // all registers but the synchronisers; reset lands in high-speed run with clock on
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg <= ST_RUN;
            standby_reg <= STANDBY_RST;
            osc_reg <= OSC_RST;
            wake_en_reg <= WAKE_EN_RST;
            run_low_reg <= 1'b0;
            manual_reg <= 1'b0;
            wu_ok_reg <= 1'b0;
            pll_cnt_reg <= 13'h0;
            nmi_prev_reg <= 1'b1;
            kind_reg <= KIND_NONE;
            halt_reg <= 1'b0;
            clk_en_reg <= 1'b1;
            go_reg <= 1'b0;
            hs_en_reg <= 1'b1;
            ls_en_reg <= 1'b1;
            pll_en_reg <= 1'b1;
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            standby_reg <= standby_next;
            osc_reg <= osc_next;
            wake_en_reg <= wake_en_next;
            run_low_reg <= run_low_next;
            manual_reg <= manual_next;
            wu_ok_reg <= wu_ok_next;
            pll_cnt_reg <= pll_cnt_next;
            nmi_prev_reg <= nmi_prev_next;
            kind_reg <= kind_next;
            halt_reg <= halt_next;
            clk_en_reg <= clk_en_next;
            go_reg <= go_next;
            hs_en_reg <= hs_en_next;
            ls_en_reg <= ls_en_next;
            pll_en_reg <= pll_en_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // outputs straight from flops
    assign o_prdata = prdata_reg;
    assign o_pready = pready_reg;
    assign o_pslverr = pslverr_reg;
    assign o_hs_osc_en = hs_en_reg;
    assign o_ls_osc_en = ls_en_reg;
    assign o_pll_en = pll_en_reg;
    assign link.core_halt = halt_reg;
    assign link.sys_clk_en = clk_en_reg;
    assign link.wake_go = go_reg;
    assign link.wake_kind = kind_reg;
endmodule : lpw_standby_ctrl

// ===== lpw_core_side.sv
// cpu core side: holds interrupt requests, issues wfi, sees handling start
// assumes peripheral requests arrive on i_clk; nmi pin is asynchronous
`timescale 1ns/1ns
module lpw_core_side (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // core requests
    input wire logic i_wfi_req,
    input wire logic [13:0] i_irq_src,
    input wire logic [13:0] i_irq_enable,
    input wire logic i_nmi_pin_n,
    input wire logic i_wdt_nmi,
    // core status
    output logic o_core_halted,
    output logic o_handler_start,
    output logic [1:0] o_handler_kind,
    output logic [13:0] o_pending,
    // controller link
    lpw_link_if.host link
);
    import lpw_pkg::*;

    logic [13:0] pending_reg, pending_next;
    logic [13:0] irq_reg, irq_next;
    logic wfi_reg, wfi_next;
    logic wdt_reg, wdt_next;
    logic nmi_s1_reg, nmi_s2_reg;
    logic halted_reg, start_reg;
    logic [1:0] kind_reg;

    // pending requests held until handling starts; new set beats clear
    always_comb begin
        pending_next = pending_reg;
        if (link.wake_go) pending_next = pending_reg & ~i_irq_enable;
        pending_next = pending_next | i_irq_src;
        irq_next = pending_next & i_irq_enable;
        wfi_next = i_wfi_req & ~link.core_halt;
        wdt_next = i_wdt_nmi;
    end

    // registers and nmi pin synchroniser
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pending_reg <= 14'h0;
            irq_reg <= 14'h0;
            wfi_reg <= 1'b0;
            wdt_reg <= 1'b0;
            nmi_s1_reg <= 1'b1;
            nmi_s2_reg <= 1'b1;
            halted_reg <= 1'b0;
            start_reg <= 1'b0;
            kind_reg <= KIND_NONE;
        end else begin
            pending_reg <= pending_next;
            irq_reg <= irq_next;
            wfi_reg <= wfi_next;
            wdt_reg <= wdt_next;
            nmi_s1_reg <= i_nmi_pin_n;
            nmi_s2_reg <= nmi_s1_reg;
            halted_reg <= link.core_halt;
            start_reg <= link.wake_go;
            kind_reg <= link.wake_go ? link.wake_kind : kind_reg;
        end
    end

    // link drive and user outputs
    assign link.irq_lines = irq_reg;
    assign link.wait_for_irq_instr = wfi_reg;
    assign link.nmi_pin_n = nmi_s2_reg;
    assign link.wdt_nmi = wdt_reg;
    assign o_core_halted = halted_reg;
    assign o_handler_start = start_reg;
    assign o_handler_kind = kind_reg;
    assign o_pending = pending_reg;
endmodule : lpw_core_side

// ===== lpw_link_checker.sv
// link checker: wake, halt and clock-enable relations between the two ends
// assumes one clock domain with synchronous active-high reset
`timescale 1ns/1ns
module lpw_link_checker (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // link signals
    input wire logic wait_for_irq_instr,
    input wire logic [13:0] irq_lines,
    input wire logic nmi_pin_n,
    input wire logic wdt_nmi,
    input wire logic core_halt,
    input wire logic sys_clk_en,
    input wire logic wake_go,
    input wire logic [1:0] wake_kind
);
    import lpw_pkg::*;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    // halt only follows a wfi
    a_halt_after_wfi: assert property ($rose(core_halt) |-> $past(wait_for_irq_instr))
        else $error("core halted without a wfi");
    // wake pulse ends a halt, lasts one cycle, names a cause
    a_go_ends_halt: assert property (wake_go |-> !core_halt && $past(core_halt))
        else $error("wake pulse without a preceding halt");
    a_go_single: assert property (wake_go |=> !wake_go)
        else $error("wake pulse longer than one cycle");
    a_go_has_kind: assert property (wake_go |-> wake_kind != KIND_NONE)
        else $error("wake pulse without a cause");
    // running core always has its clock
    a_run_clock_on: assert property (!core_halt |-> sys_clk_en)
        else $error("core running with system clock off");
    // watchdog wakes only from idle, where the clock stays on
    a_wdt_idle_only: assert property (wake_go && wake_kind == KIND_WDT |-> $past(sys_clk_en))
        else $error("watchdog wake outside idle");
    // idle leaves on a cause within two cycles, never without one
    a_idle_no_cause: assert property (core_halt && sys_clk_en && irq_lines == 14'h0
        && nmi_pin_n && !wdt_nmi |=> !wake_go)
        else $error("idle left without a cause");
    a_idle_irq_wakes: assert property (core_halt && sys_clk_en && irq_lines != 14'h0
        |-> ##[0:2] wake_go)
        else $error("idle kept despite a request");
    a_idle_pin_wakes: assert property (core_halt && sys_clk_en && $fell(nmi_pin_n)
        |-> ##[0:2] wake_go)
        else $error("idle kept despite pin fall");
endmodule : lpw_link_checker

// ===== low_power_wake_warmup_tb.sv
// bench: controller and core side joined over the link, apb register access
// assumes free-running oscillator stand-ins of 3 and 5 clock periods
`timescale 1ns/1ns
module low_power_wake_warmup_tb;
    import lpw_pkg::*;
    localparam int PLL = 10;
    localparam int WU = 1;
    logic clk = 1'b0, rst = 1'b1, hs_clk = 1'b0, ls_clk = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, pll_en, halted, h_start, hs_en, ls_en;
    logic wfi_req = 1'b0, nmi_n = 1'b1, wdt = 1'b0;
    logic [13:0] irq_src = 14'h0, pend;
    logic [1:0] h_kind;
    int fail_count = 0, checked = 0, cycles = 0, seed = 72149;

    // clocks: system and the two oscillators
    always #20 clk = ~clk;
    always #60 hs_clk <= ~hs_clk;
    always #100 ls_clk <= ~ls_clk;

    lpw_link_if lpw_link_if_i ();
    lpw_standby_ctrl #(.PLL_CYC(PLL), .WU_SHIFT(WU)) lpw_standby_ctrl_i (
        .i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_hs_osc_clk(hs_clk), .i_ls_osc_clk(ls_clk),
        .o_hs_osc_en(hs_en), .o_ls_osc_en(ls_en), .o_pll_en(pll_en), .link(lpw_link_if_i));
    lpw_core_side lpw_core_side_i (
        .i_clk(clk), .i_rst(rst), .i_wfi_req(wfi_req), .i_irq_src(irq_src),
        .i_irq_enable(14'h3fff), .i_nmi_pin_n(nmi_n), .i_wdt_nmi(wdt),
        .o_core_halted(halted), .o_handler_start(h_start), .o_handler_kind(h_kind),
        .o_pending(pend), .link(lpw_link_if_i));
    lpw_link_checker lpw_link_checker_i (
        .i_clk(clk), .i_rst(rst), .wait_for_irq_instr(lpw_link_if_i.wait_for_irq_instr),
        .irq_lines(lpw_link_if_i.irq_lines), .nmi_pin_n(lpw_link_if_i.nmi_pin_n),
        .wdt_nmi(lpw_link_if_i.wdt_nmi), .core_halt(lpw_link_if_i.core_halt),
        .sys_clk_en(lpw_link_if_i.sys_clk_en), .wake_go(lpw_link_if_i.wake_go),
        .wake_kind(lpw_link_if_i.wake_kind));

    // verdict and end of run
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // wake permission per mode, worked out from the source groups
    function automatic logic allowed(input logic [2:0] m, input int b);
        return m == MODE_IDLE || (m == MODE_SLEEP && b < OTHER_BIT) || b < RTC_BIT;
    endfunction : allowed

    // shortest wake delay for a warm-up of time code t
    function automatic int warm_min(input int t, input int per);
        int c;
        c = ((1 << (WU + t)) - 1) * per;
        return (c > PLL) ? c : PLL;
    endfunction : warm_min

    // one apb transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r & m, x);
        chk(32'(e), 32'h0);
    endtask : rd

    task automatic busy_wait;
        logic [31:0] r;
        logic e;
        int i;
        i = 0;
        repeat (2) @(posedge clk);
        do begin
            apb(1'b0, OFS_STATUS, 32'h0, r, e);
            i++;
        end while (r[ST_WBUSY_BIT] !== 1'b0 && i < 100);
    endtask : busy_wait

    // core-side stimulus: wfi pulse, request pulse, wait for handling
    task automatic wfi_go;
        @(posedge clk);
        wfi_req <= 1'b1;
        @(posedge clk);
        wfi_req <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : wfi_go

    task automatic pulse(input int b);
        @(posedge clk);
        irq_src <= 14'h0001 << b;
        @(posedge clk);
        irq_src <= 14'h0;
    endtask : pulse

    task automatic wake_wait(input int lim, output int n, output logic [1:0] k);
        n = -1;
        k = 2'bxx;
        for (int i = 0; i < lim && n < 0; i++) begin
            @(posedge clk);
            if (h_start === 1'b1) begin
                n = i;
                k = h_kind;
            end
        end
    endtask : wake_wait

    task automatic nmi_wake;
        int n;
        logic [1:0] k;
        @(posedge clk);
        nmi_n <= 1'b0;
        wake_wait(150, n, k);
        nmi_n <= 1'b1;
        chk(32'(k), 32'(KIND_NMI_PIN));
    endtask : nmi_wake

    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            wrap_up();
        end
    end

    // main sequence
    initial begin
        logic [31:0] r;
        logic e;
        logic [1:0] k;
        logic [2:0] m;
        int n;
        int t;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_STANDBY, 32'h1f, 32'h0);
        rd(OFS_OSC, 32'h7f, 32'h30);
        rd(OFS_STATUS, 32'h7f, 32'h01);
        apb(1'b0, 8'h10, 32'h0, r, e);
        chk(32'(e), 32'h1);
        r = $random(seed);
        wr(OFS_WAKE_EN, r);
        rd(OFS_WAKE_EN, 32'hffffffff, {18'h0, r[13:0]});
        wr(OFS_WAKE_EN, 32'h3fff);
        wfi_go();
        chk(32'(halted), 32'h0);
        $display("test registers finished");
        // every wake source in every standby mode
        for (int mi = 0; mi < 3; mi++) begin
            m = (mi == 0) ? MODE_IDLE : (mi == 1) ? MODE_SLEEP : MODE_STOP;
            for (int b = 0; b < WAKE_W; b++) begin
                t = $unsigned($random(seed)) % 3;
                wr(OFS_OSC, 32'h30 | (t << 1));
                wr(OFS_STANDBY, {29'h0, m});
                wfi_go();
                chk(32'(halted), 32'h1);
                chk(32'(pll_en), 32'(m == MODE_IDLE));
                chk({30'h0, hs_en, ls_en}, {30'h0, m == MODE_IDLE, m != MODE_STOP});
                pulse(b);
                wake_wait(150, n, k);
                if (allowed(m, b)) begin
                    chk(32'(k), 32'(KIND_IRQ));
                    chk(32'(m == MODE_IDLE || n >= warm_min(t, 3)), 32'h1);
                    chk(32'(pend), 32'h0);
                end else begin
                    chk(n, 32'hffffffff);
                    nmi_wake();
                end
            end
        end
        $display("test wake sources finished");
        wr(OFS_STANDBY, {29'h0, MODE_SLEEP});
        wfi_go();
        wdt <= 1'b1;
        wake_wait(60, n, k);
        chk(n, 32'hffffffff);
        wdt <= 1'b0;
        nmi_wake();
        wr(OFS_STANDBY, {29'h0, MODE_IDLE});
        wfi_go();
        wdt <= 1'b1;
        wake_wait(20, n, k);
        wdt <= 1'b0;
        chk(32'(k), 32'(KIND_WDT));
        $display("test watchdog finished");
        // low-speed run: manual warm-up, sleep and stop round trips
        wr(OFS_STANDBY, 32'h12);
        wr(OFS_OSC, 32'h71);
        busy_wait();
        rd(OFS_STATUS, 32'h3f, 32'h21);
        wfi_go();
        pulse(0);
        wake_wait(40, n, k);
        chk(32'(n >= 0 && n <= 4), 32'h1);
        rd(OFS_STATUS, 32'h3f, 32'h21);
        wr(OFS_OSC, 32'h33);
        wr(OFS_STANDBY, 32'h11);
        wfi_go();
        pulse(0);
        wake_wait(150, n, k);
        chk(32'(n >= warm_min(1, 5)), 32'h1);
        rd(OFS_STATUS, 32'h3f, 32'h21);
        wr(OFS_STANDBY, 32'h01);
        wr(OFS_OSC, 32'h70);
        busy_wait();
        rd(OFS_STATUS, 32'h3f, 32'h01);
        $display("test low speed finished");
        // reset pin while in stop
        wfi_go();
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        chk(32'(halted), 32'h0);
        rd(OFS_STATUS, 32'h7f, 32'h01);
        rd(OFS_STANDBY, 32'h1f, 32'h0);
        $display("test reset in stop finished");
        wrap_up();
    end
endmodule : low_power_wake_warmup_tb
